/* File: pmb_pkg.sv */
// pmb_pkg: shared constants and types of the converter command link.
// assumes one 250 MHz clock shared by the host and the device ends.
package pmb_pkg;
	// clock and pacing times
	localparam int CLK_KHZ      = 250000;
	localparam int NV_WAIT_MS   = 100;
	localparam int READ_GAP_MS  = 2;
	localparam int WRITE_GAP_MS = 5;
	localparam int NV_CYC    = NV_WAIT_MS * CLK_KHZ;
	localparam int READ_CYC  = READ_GAP_MS * CLK_KHZ;
	localparam int WRITE_CYC = WRITE_GAP_MS * CLK_KHZ;
	localparam int TOFF_CYC  = 16; // soft-off ramp length
	localparam int CNT_W     = 25;
	// command codes
	localparam logic [7:0] CMD_PAGE    = 8'h00;
	localparam logic [7:0] CMD_OPER    = 8'h01;
	localparam logic [7:0] CMD_ONOFF   = 8'h02;
	localparam logic [7:0] CMD_CLEAR   = 8'h03;
	localparam logic [7:0] CMD_STORE   = 8'h15;
	localparam logic [7:0] CMD_RESTORE = 8'h16;
	localparam logic [7:0] CMD_VCMD    = 8'h21;
	localparam logic [7:0] CMD_TRIM    = 8'h22;
	localparam logic [7:0] CMD_TEXT    = 8'hb0;
	// page values
	localparam logic [7:0] PAGE_P2   = 8'h00;
	localparam logic [7:0] PAGE_P1   = 8'h01;
	localparam logic [7:0] PAGE_BOTH = 8'hff;
	// operation field codes, bits 7:6 and 5:4
	localparam logic [1:0] OP_IMM_OFF  = 2'h0;
	localparam logic [1:0] OP_SOFT_OFF = 2'h1;
	localparam logic [1:0] OP_ON       = 2'h2;
	localparam logic [1:0] MRG_NOM     = 2'h0;
	localparam logic [1:0] MRG_LOW     = 2'h1;
	localparam logic [1:0] MRG_HIGH    = 2'h2;
	// reset values
	localparam logic [7:0]  PAGE_RST  = 8'h00;
	localparam logic [7:0]  ONOFF_RST = 8'h17;
	localparam logic [15:0] VCMD_RST  = 16'h0000;
	localparam logic [15:0] TRIM_RST  = 16'h0000;
	localparam int TEXT_MAX = 4;
	// linear-eleven layout
	localparam int L11_EXP_POS = 11;
	localparam int L11_EXP_W   = 5;
	localparam int L11_MAN_W   = 11;
	// host register byte offsets
	localparam logic [4:0] REG_CTRL  = 5'h00;
	localparam logic [4:0] REG_WDATA = 5'h04;
	localparam logic [4:0] REG_RDATA = 5'h08;
	localparam logic [4:0] REG_STAT  = 5'h0c;
	localparam logic [4:0] REG_L11   = 5'h10;
	typedef enum logic [1:0] {OUT_OFF, OUT_RAMP, OUT_ON} pmb_out_type;
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV, H_PACE} pmb_hst_type;
endpackage

/* File: pmb_link_if.sv */
// pmb_link_if: byte link between host end and device end.
// assumes both ends sit on the same clock; the bench joins them.
`timescale 1ns/1ns
interface pmb_link_if;
	logic       h_valid; // host byte strobe
	logic [7:0] h_byte;
	logic       h_first; // command code byte
	logic       h_last;  // last byte of frame
	logic       h_read;  // with h_first: read request
	logic       d_valid; // device byte strobe
	logic [7:0] d_byte;
	logic       d_last;
	logic       d_nack;  // frame refused
	modport host (output h_valid, h_byte, h_first, h_last, h_read,
		input d_valid, d_byte, d_last, d_nack);
	modport dev (input h_valid, h_byte, h_first, h_last, h_read,
		output d_valid, d_byte, d_last, d_nack);
endinterface

/* File: pmb_host.sv */
// pmb_host: link host, driven by software over classic wishbone.
// assumes a single-cycle wishbone master and the device on the link.
`timescale 1ns/1ns
module pmb_host #(
	parameter int unsigned NV_GAP    = pmb_pkg::NV_CYC,
	parameter int unsigned READ_GAP  = pmb_pkg::READ_CYC,
	parameter int unsigned WRITE_GAP = pmb_pkg::WRITE_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// link
	pmb_link_if.host         lk
);
	typedef struct packed {
		logic                 ack;
		logic [31:0]          dat;
		logic [7:0]           code;
		logic                 rd, blk, nack;
		logic [2:0]           nb, idx, rlen;
		logic [3:0][7:0]      wdata, rdata;
		pmb_pkg::pmb_hst_type st;
		logic [24:0]          pace;
		logic                 hv, hf, hl, hr;
		logic [7:0]           hb;
	} pmb_hst_st_type;
	pmb_hst_st_type s, next_s;

	// bus decode, frame send, answer capture and pacing
	always_comb begin
		logic [2:0] tot;
		logic [2:0] pos;
		next_s = s;
		tot = s.blk ? 3'(s.nb + 3'h1) : s.nb;
		pos = 3'h0;
		next_s.ack = 1'b0;
		next_s.hv = 1'b0;
		next_s.hf = 1'b0;
		next_s.hl = 1'b0;
		next_s.hr = 1'b0;
		unique case (s.st)
			pmb_pkg::H_IDLE: ;
			pmb_pkg::H_SEND: begin
				next_s.hv = 1'b1;
				next_s.idx = 3'(s.idx + 3'h1);
				if (s.idx == 3'h0) begin
					next_s.hb = s.code;
					next_s.hf = 1'b1;
					next_s.hr = s.rd;
				end else if (s.blk && s.idx == 3'h1) begin
					next_s.hb = {5'h00, s.nb};
				end else begin
					pos = s.blk ? 3'(s.idx - 3'h2) : 3'(s.idx - 3'h1);
					next_s.hb = s.wdata[pos[1:0]];
				end
				if (s.rd || s.idx == tot) begin
					next_s.hl = 1'b1;
					next_s.idx = 3'h0;
					next_s.st = s.rd ? pmb_pkg::H_RECV
						: pmb_pkg::H_PACE;
				end
			end
			pmb_pkg::H_RECV: begin
				if (lk.d_valid) begin
					next_s.idx = 3'(s.idx + 3'h1);
					if (s.blk && s.idx == 3'h0)
						next_s.rlen = lk.d_byte[2:0];
					else begin
						pos = s.blk ? 3'(s.idx - 3'h1) : s.idx;
						if (!pos[2])
							next_s.rdata[pos[1:0]] = lk.d_byte;
					end
				end
				if (lk.d_nack || (lk.d_valid && lk.d_last))
					next_s.st = pmb_pkg::H_PACE;
			end
			pmb_pkg::H_PACE: begin
				// no new frame until the gap has run out
				if (s.pace == 25'h000_0000)
					next_s.st = pmb_pkg::H_IDLE;
				else
					next_s.pace = 25'(s.pace - 25'h000_0001);
			end
		endcase
		// gap follows the frame just sent
		if (s.st == pmb_pkg::H_SEND) begin
			if (s.code == pmb_pkg::CMD_STORE
				|| s.code == pmb_pkg::CMD_RESTORE)
				next_s.pace = 25'(NV_GAP);
			else if (s.rd)
				next_s.pace = 25'(READ_GAP);
			else
				next_s.pace = 25'(WRITE_GAP);
		end
		// register access, answered one cycle after the request
		if (cyc_i && stb_i && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.dat = 32'h0000_0000;
			unique case (adr_i)
				pmb_pkg::REG_CTRL: next_s.dat = {19'h0_0000, s.nb,
					s.blk, s.rd, s.code};
				pmb_pkg::REG_WDATA: next_s.dat = s.wdata;
				pmb_pkg::REG_RDATA: next_s.dat = s.rdata;
				pmb_pkg::REG_STAT: next_s.dat = {21'h00_0000, s.rlen,
					6'h00, s.nack, s.st != pmb_pkg::H_IDLE};
				pmb_pkg::REG_L11: next_s.dat = {
					{3{s.rdata[1][7]}}, s.rdata[1][7:3], 8'h00,
					{5{s.rdata[1][2]}}, s.rdata[1][2:0], s.rdata[0]};
				default: ;
			endcase
			if (we_i && adr_i == pmb_pkg::REG_WDATA) begin
				for (int j = 0; j < 4; j++)
					if (sel_i[j])
						next_s.wdata[j] = dat_i[8*j +: 8];
			end
			// a start while a frame is in flight is dropped
			if (we_i && adr_i == pmb_pkg::REG_CTRL
				&& s.st == pmb_pkg::H_IDLE) begin
				next_s.code = dat_i[7:0];
				next_s.rd = dat_i[8];
				next_s.blk = dat_i[9];
				next_s.nb = dat_i[12:10] > 3'h4 ? 3'h4 : dat_i[12:10];
				next_s.idx = 3'h0;
				next_s.nack = 1'b0;
				next_s.rlen = 3'h0;
				next_s.rdata = 32'h0000_0000;
				next_s.st = pmb_pkg::H_SEND;
			end
		end
		if (lk.d_nack)
			next_s.nack = 1'b1; // set wins over clear
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign dat_o = s.dat;
	assign ack_o = s.ack;
	assign lk.h_valid = s.hv;
	assign lk.h_byte = s.hb;
	assign lk.h_first = s.hf;
	assign lk.h_last = s.hl;
	assign lk.h_read = s.hr;
endmodule

/* File: pmb_dev.sv */
// pmb_dev: command interpreter of the two-phase converter.
// assumes the host paces frames and drives the link by its modport.
// What the document asks
// - host keeps output off for setting writes; this block takes them with output on too
// - listed commands act while output enabled
// - any supported command readable any time; this block nacks reads while busy and of clear, store, restore
// - trim applies only after off then on
// - host waits 100ms after store/restore
// - host leaves 2ms between reads
// - host leaves 5ms between other commands
// - store, power cycle, re-enable to confirm
// - linear eleven: 5-bit exponent, 11-bit mantissa
// - unsigned sixteen-bit mantissa, exponent minus thirteen
// - signed sixteen-bit mantissa, exponent minus thirteen
// - text is variable-length ASCII bytes
// - block data leads with byte count
// - page 00 phase two, 01 one, ff both
// - later commands go to selected phases
// - operation read shows actual output state
// - immediate off shuts down at once
// - 01 soft off, 10 on, low nibble zero
// - margin field: nominal, low, high
// - unlisted operation codes flag command error
// - operation acts now, not stored
`timescale 1ns/1ns
module pmb_dev #(
	parameter int unsigned NV_BUSY = pmb_pkg::NV_CYC
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// link
	pmb_link_if.dev               lk,
	// converter side
	output logic      [1:0]       phase_on_o,
	output logic      [1:0][1:0]  margin_o,
	output logic      [1:0][15:0] vout_o,
	output logic                  cmd_err_o,
	output logic                  nv_busy_o
);
	typedef struct packed {
		logic [7:0]                  page;
		pmb_pkg::pmb_out_type [1:0]  ost;
		logic [1:0]                  pon;
		logic [1:0][1:0]             mrg;
		logic [1:0][7:0]             tcnt;
		logic [1:0][15:0]            vcmd, trim, trim_act, vout;
		logic [7:0]                  onoff, nv_onoff;
		logic [3:0][7:0]             text, nv_text;
		logic [2:0]                  tlen, nv_tlen;
		logic [1:0][15:0]            nv_vcmd, nv_trim;
		logic [7:0]                  code;
		logic                        drop, err, busy;
		logic [2:0]                  cnt;
		logic [4:0][7:0]             rx, tx;
		logic [2:0]                  tx_idx, tx_len;
		logic                        tx_on;
		logic [24:0]                 bcnt;
		logic                        dv, dl, dn;
		logic [7:0]                  db;
	} pmb_dev_st_type;
	pmb_dev_st_type s, next_s;

	// frame decode, command execution, read answer and ramp timing
	always_comb begin
		logic [4:0][7:0] wb;
		logic [2:0]      nb;
		logic            go;
		logic [1:0]      sel;
		logic            ri;
		logic [7:0]      op;
		logic            bad;
		next_s = s;
		wb = s.rx;
		nb = s.cnt;
		go = 1'b0;
		ri = s.page == pmb_pkg::PAGE_P1;
		sel = s.page == pmb_pkg::PAGE_BOTH ? 2'h3
			: (ri ? 2'h2 : 2'h1);
		op = 8'h00;
		bad = 1'b0;
		next_s.dv = 1'b0;
		next_s.dl = 1'b0;
		next_s.dn = 1'b0;
		// store and restore leave the device deaf for a while
		if (s.bcnt != 25'h000_0000)
			next_s.bcnt = 25'(s.bcnt - 25'h000_0001);
		// soft off runs its ramp before the state goes off; phase_on_o drops at once
		for (int i = 0; i < 2; i++) begin
			if (s.ost[i] == pmb_pkg::OUT_RAMP) begin
				if (s.tcnt[i] == 8'h00)
					next_s.ost[i] = pmb_pkg::OUT_OFF;
				else
					next_s.tcnt[i] = 8'(s.tcnt[i] - 8'h01);
			end
		end
		// answer bytes, one per cycle
		if (s.tx_on) begin
			next_s.dv = 1'b1;
			next_s.db = s.tx[s.tx_idx];
			next_s.dl = s.tx_idx == 3'(s.tx_len - 3'h1);
			next_s.tx_idx = 3'(s.tx_idx + 3'h1);
			if (next_s.dl)
				next_s.tx_on = 1'b0;
		end
		if (lk.h_valid && lk.h_first) begin
			next_s.code = lk.h_byte;
			next_s.cnt = 3'h0;
			next_s.drop = s.bcnt != 25'h000_0000;
			if (next_s.drop)
				next_s.dn = 1'b1;
			else if (lk.h_read) begin
				// reads are served in any output state
				next_s.drop = 1'b1;
				next_s.tx_idx = 3'h0;
				next_s.tx_len = 3'h1;
				next_s.tx_on = 1'b1;
				next_s.tx = '0;
				unique case (lk.h_byte)
					pmb_pkg::CMD_PAGE: next_s.tx[0] = s.page;
					pmb_pkg::CMD_OPER: begin
						unique case (s.ost[ri])
							pmb_pkg::OUT_ON: next_s.tx[0] = {
								pmb_pkg::OP_ON, s.mrg[ri], 4'h0};
							pmb_pkg::OUT_RAMP: next_s.tx[0] = {
								pmb_pkg::OP_SOFT_OFF, 6'h00};
							default: next_s.tx[0] = 8'h00;
						endcase
					end
					pmb_pkg::CMD_ONOFF: next_s.tx[0] = s.onoff;
					pmb_pkg::CMD_VCMD: begin
						next_s.tx[1:0] = s.vcmd[ri];
						next_s.tx_len = 3'h2;
					end
					pmb_pkg::CMD_TRIM: begin
						next_s.tx[1:0] = s.trim[ri];
						next_s.tx_len = 3'h2;
					end
					pmb_pkg::CMD_TEXT: begin
						next_s.tx[0] = {5'h00, s.tlen};
						for (int k = 0; k < 4; k++)
							next_s.tx[k + 1] = s.text[k];
						next_s.tx_len = 3'(s.tlen + 3'h1);
					end
					default: begin
						next_s.tx_on = 1'b0;
						next_s.dn = 1'b1;
					end
				endcase
			end else if (lk.h_last) begin
				go = 1'b1;
				nb = 3'h0;
			end
		end else if (lk.h_valid && !s.drop) begin
			wb[s.cnt] = lk.h_byte;
			nb = 3'(s.cnt + 3'h1);
			next_s.rx = wb;
			next_s.cnt = s.cnt == 3'h4 ? s.cnt : nb;
			go = lk.h_last;
		end
		if (go) begin
			unique case (next_s.code)
				pmb_pkg::CMD_PAGE: begin
					bad = nb != 3'h1 || !(wb[0] == pmb_pkg::PAGE_P2
						|| wb[0] == pmb_pkg::PAGE_P1
						|| wb[0] == pmb_pkg::PAGE_BOTH);
					if (!bad)
						next_s.page = wb[0];
				end
				pmb_pkg::CMD_OPER: begin
					op = wb[0];
					bad = nb != 3'h1 || op[3:0] != 4'h0
						|| op[7:6] == 2'h3 || op[5:4] == 2'h3
						|| (op[7:6] != pmb_pkg::OP_ON
						&& op[5:4] != pmb_pkg::MRG_NOM);
					// acts at once; never copied to the store
					for (int i = 0; i < 2; i++) begin
						if (!bad && sel[i]) begin
							unique case (op[7:6])
								pmb_pkg::OP_IMM_OFF:
									next_s.ost[i] = pmb_pkg::OUT_OFF;
								pmb_pkg::OP_SOFT_OFF: begin
									if (s.ost[i] == pmb_pkg::OUT_ON) begin
										next_s.ost[i] = pmb_pkg::OUT_RAMP;
										next_s.tcnt[i] = 8'(pmb_pkg::TOFF_CYC);
									end
								end
								default: begin
									if (s.ost[i] != pmb_pkg::OUT_ON)
										next_s.trim_act[i] = s.trim[i];
									next_s.ost[i] = pmb_pkg::OUT_ON;
									next_s.mrg[i] = op[5:4];
								end
							endcase
						end
					end
				end
				pmb_pkg::CMD_ONOFF: begin
					bad = nb != 3'h1;
					if (!bad)
						next_s.onoff = wb[0];
				end
				pmb_pkg::CMD_CLEAR: bad = nb != 3'h0;
				pmb_pkg::CMD_STORE: begin
					bad = nb != 3'h0;
					if (!bad) begin
						next_s.nv_vcmd = s.vcmd;
						next_s.nv_trim = s.trim;
						next_s.nv_onoff = s.onoff;
						next_s.nv_text = s.text;
						next_s.nv_tlen = s.tlen;
						next_s.bcnt = 25'(NV_BUSY);
					end
				end
				pmb_pkg::CMD_RESTORE: begin
					bad = nb != 3'h0;
					if (!bad) begin
						next_s.vcmd = s.nv_vcmd;
						next_s.trim = s.nv_trim;
						next_s.onoff = s.nv_onoff;
						next_s.text = s.nv_text;
						next_s.tlen = s.nv_tlen;
						next_s.ost = '{pmb_pkg::OUT_OFF, pmb_pkg::OUT_OFF};
						next_s.mrg = '0;
						next_s.bcnt = 25'(NV_BUSY);
					end
				end
				pmb_pkg::CMD_VCMD, pmb_pkg::CMD_TRIM: begin
					bad = nb != 3'h2;
					for (int i = 0; i < 2; i++) begin
						if (!bad && sel[i]) begin
							if (next_s.code == pmb_pkg::CMD_VCMD)
								next_s.vcmd[i] = wb[1:0];
							else
								next_s.trim[i] = wb[1:0];
						end
					end
				end
				pmb_pkg::CMD_TEXT: begin
					bad = nb == 3'h0 || wb[0] != {5'h00, 3'(nb - 3'h1)};
					if (!bad) begin
						next_s.tlen = wb[0][2:0];
						for (int k = 0; k < 4; k++)
							next_s.text[k] = wb[k + 1];
					end
				end
				default: bad = 1'b1;
			endcase
			if (next_s.code == pmb_pkg::CMD_CLEAR && !bad)
				next_s.err = 1'b0;
			if (bad)
				next_s.err = 1'b1;
		end
		// target = unsigned command plus signed trim, both 2^-13 V
		for (int i = 0; i < 2; i++) begin
			next_s.vout[i] = 16'(next_s.vcmd[i] + next_s.trim_act[i]);
			next_s.pon[i] = next_s.ost[i] == pmb_pkg::OUT_ON;
		end
		next_s.busy = next_s.bcnt != 25'h000_0000;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.page <= pmb_pkg::PAGE_RST;
			s.onoff <= pmb_pkg::ONOFF_RST;
			s.nv_onoff <= pmb_pkg::ONOFF_RST;
			s.vcmd <= {2{pmb_pkg::VCMD_RST}};
			s.nv_vcmd <= {2{pmb_pkg::VCMD_RST}};
			s.trim <= {2{pmb_pkg::TRIM_RST}};
			s.nv_trim <= {2{pmb_pkg::TRIM_RST}};
			s.trim_act <= {2{pmb_pkg::TRIM_RST}};
			s.vout <= {2{pmb_pkg::VCMD_RST}};
		end else
			s <= next_s;
	end

	assign lk.d_valid = s.dv;
	assign lk.d_byte = s.db;
	assign lk.d_last = s.dl;
	assign lk.d_nack = s.dn;
	assign phase_on_o = s.pon;
	assign margin_o = s.mrg;
	assign vout_o = s.vout;
	assign cmd_err_o = s.err;
	assign nv_busy_o = s.busy;
endmodule

/* File: pmb_link_checker.sv */
// pmb_link_checker: assertions on the host/device byte link.
// assumes the pacing parameters equal those handed to the host.
`timescale 1ns/1ns
module pmb_link_checker #(
	parameter int unsigned NV_GAP    = 20,
	parameter int unsigned READ_GAP  = 8,
	parameter int unsigned WRITE_GAP = 12
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// host side of the link
	input wire logic       h_valid,
	input wire logic [7:0] h_byte,
	input wire logic       h_first,
	input wire logic       h_last,
	input wire logic       h_read,
	// device side of the link
	input wire logic       d_valid,
	input wire logic [7:0] d_byte,
	input wire logic       d_last,
	input wire logic       d_nack
);
	logic [7:0]  code;  // code of the frame in flight
	logic [7:0]  page;  // last legal page written
	logic        pg_ok; // store/restore may reload the page
	logic        pg_wr; // next host byte is a page value
	logic [1:0]  kind;  // last frame: 0 other, 1 read, 2 store/restore
	logic [10:0] gap;   // saturating cycles since frame end
	logic [7:0]  fc;
	logic        rq;
	assign fc = h_first ? h_byte : code;
	assign rq = h_valid && h_first && h_read;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// follow page writes, frame kinds and pacing distance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code  <= 8'h00;
			page  <= 8'h00;
			pg_ok <= 1'b1;
			pg_wr <= 1'b0;
			kind  <= 2'h0;
			gap   <= 11'h7ff;
		end else begin
			if (h_valid && h_first)
				code <= h_byte;
			pg_wr <= h_valid && h_first && !h_read && h_byte == 8'h00;
			if (pg_wr && h_valid && (h_byte == 8'h00 || h_byte == 8'h01
				|| h_byte == 8'hff)) begin
				page  <= h_byte;
				pg_ok <= 1'b1;
			end
			// restore may rewrite the page, so stop predicting it
			if (h_valid && h_first && (h_byte == 8'h15 || h_byte == 8'h16))
				pg_ok <= 1'b0;
			if (h_valid && h_last) begin
				gap  <= 11'h000;
				kind <= rq ? 2'h1 : (fc == 8'h15 || fc == 8'h16) ? 2'h2 : 2'h0;
			end else if (gap != 11'h7ff)
				gap <= gap + 11'h001;
		end
	end
	a_read_answered:
	// refusal shows one cycle after the code byte, data one cycle later
	assert property (rq |=> (d_nack or (##1 d_valid)))
	else $error("read request left unanswered");
	a_page_readback:
	assert property (rq && h_byte == 8'h00 && pg_ok |->
		##2 d_valid && d_last && d_byte == page)
	else $error("page readback differs from last page written");
	a_oper_state:
	assert property (rq && h_byte == 8'h01 |->
		##2 d_valid && d_byte[3:0] == 4'h0 && d_byte[7:6] != 2'h3)
	else $error("operation readback has an illegal state");
	a_oper_margin:
	assert property (rq && h_byte == 8'h01 |-> ##2 d_byte[5:4] != 2'h3
		&& (d_byte[7:6] == 2'h2 || d_byte[5:4] == 2'h0))
	else $error("operation readback margin wrong");
	a_block_count:
	assert property (rq && h_byte == 8'hb0 |-> ##2 d_valid && d_byte <= 8'h04)
	else $error("block answer count missing or too big");
	a_block_frame:
	assert property (h_valid && h_first && !h_read && h_byte == 8'hb0
		|=> h_valid && h_byte <= 8'h04)
	else $error("block write lacks its count byte");
	a_word_frame:
	assert property (h_valid && h_first && !h_read
		&& (h_byte == 8'h21 || h_byte == 8'h22)
		|=> h_valid && !h_last ##1 h_valid && h_last)
	else $error("word write is not two data bytes");
	a_nv_pacing:
	assert property (h_valid && h_first && kind == 2'h2 |-> gap + 1 >= NV_GAP)
	else $error("frame sent too soon after store or restore");
	a_read_pacing:
	assert property (h_valid && h_first && kind == 2'h1 |-> gap + 1 >= READ_GAP)
	else $error("frame sent too soon after a read");
	a_write_pacing:
	assert property (h_valid && h_first && kind == 2'h0
		|-> gap + 1 >= WRITE_GAP)
	else $error("frame sent too soon after a write");
endmodule

/* File: pmbus_page_operation_commands_bench.sv */
// bench: host and device joined over the link, driven over wishbone.
// assumes short pacing parameters so the run stays brief.
`timescale 1ns/1ns
module pmbus_page_operation_commands_bench;
	localparam logic [7:0] PG [3] = '{8'h00, 8'h01, 8'hff};
	localparam logic [1:0] PON [3] = '{2'h1, 2'h2, 2'h3};
	logic             clk_i;
	logic             rst_i;
	logic             cyc_i;
	logic             stb_i;
	logic             we_i;
	logic      [4:0]  adr_i;
	logic      [3:0]  sel_i;
	logic      [31:0] dat_i;
	logic      [31:0] dat_o;
	logic             ack_o;
	logic      [1:0]  phase_on_o;
	logic [1:0][1:0]  margin_o;
	logic [1:0][15:0] vout_o;
	logic             cmd_err_o;
	logic             nv_busy_o;
	logic             saw_nv;
	logic      [31:0] seed;
	int               n_fail;
	int               n_compared;
	int               cyc_cnt;
	pmb_link_if pmb_link_if_i ();
	pmb_host #(.NV_GAP(20), .READ_GAP(8), .WRITE_GAP(12)) pmb_host_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .lk(pmb_link_if_i));
	pmb_dev #(.NV_BUSY(20)) pmb_dev_i (
		.clk_i(clk_i), .rst_i(rst_i), .lk(pmb_link_if_i),
		.phase_on_o(phase_on_o), .margin_o(margin_o), .vout_o(vout_o),
		.cmd_err_o(cmd_err_o), .nv_busy_o(nv_busy_o));
	// checker defaults already match the short gaps given to the host
	pmb_link_checker pmb_link_checker_i (
		.clk_i(clk_i), .rst_i(rst_i),
		.h_valid(pmb_link_if_i.h_valid), .h_byte(pmb_link_if_i.h_byte),
		.h_first(pmb_link_if_i.h_first), .h_last(pmb_link_if_i.h_last),
		.h_read(pmb_link_if_i.h_read), .d_valid(pmb_link_if_i.d_valid),
		.d_byte(pmb_link_if_i.d_byte), .d_last(pmb_link_if_i.d_last),
		.d_nack(pmb_link_if_i.d_nack));
	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] ctl(input logic [7:0] c,
		input logic rd, input logic blk, input logic [2:0] n);
		return {19'h0_0000, n, blk, rd, c};
	endfunction
	// expected linear-eleven view: exponent and mantissa sign-extended
	function automatic logic [31:0] l11(input logic [15:0] x);
		return {{3{x[15]}}, x[15:11], 8'h00, {5{x[10]}}, x[10:0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one classic cycle; the answer may take any number of cycles
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// one link frame: load data, start, wait for busy to clear, fetch
	task automatic xfer(input logic [31:0] c, input logic [31:0] d,
		output logic [31:0] r, output logic [31:0] s);
		wb(1'b1, pmb_pkg::REG_WDATA, d, r);
		wb(1'b1, pmb_pkg::REG_CTRL, c, r);
		do wb(1'b0, pmb_pkg::REG_STAT, 32'h0, s); while (s[0] !== 1'b0);
		wb(1'b0, pmb_pkg::REG_RDATA, 32'h0, r);
	endtask
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard and store-busy watcher
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (nv_busy_o === 1'b1)
			saw_nv = 1'b1;
		if (cyc_cnt == 12000) begin
			n_fail++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		logic [31:0] r, s, v, t, w, e;
		logic [15:0] ev [2];
		int n;
		{rst_i, sel_i, seed} = {1'b1, 4'hf, 32'h0000_fa08};
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		{n_fail, n_compared, cyc_cnt, saw_nv} = '0;
		ev = '{16'h0000, 16'h0000};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(ctl(pmb_pkg::CMD_PAGE, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'h0);
		xfer(ctl(pmb_pkg::CMD_OPER, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'h0);
		chk(32'(phase_on_o), 32'h0);
		xfer(ctl(pmb_pkg::CMD_ONOFF, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'(pmb_pkg::ONOFF_RST));
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			xfer(ctl(pmb_pkg::CMD_PAGE, 0, 0, 1), 32'(PG[i]), r, s);
			v = rnd() & 32'h0000_ffff;
			xfer(ctl(pmb_pkg::CMD_VCMD, 0, 0, 2), v, r, s);
			if (PG[i] != 8'h01)
				ev[0] = v[15:0];
			if (PG[i] != 8'h00)
				ev[1] = v[15:0];
			chk(32'(vout_o), {ev[1], ev[0]});
			xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), 32'h0000_0080, r, s);
			chk(32'(phase_on_o), 32'(PON[i]));
			xfer(ctl(pmb_pkg::CMD_PAGE, 1, 0, 1), 32'h0, r, s);
			chk(r, 32'(PG[i]));
			xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), 32'h0, r, s);
			chk(32'(phase_on_o), 32'h0);
		end
		$display("page test done");
		for (int m = 0; m < 3; m++) begin
			e = 32'h0000_0080 | 32'(m << 4);
			xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), e, r, s);
			chk(32'(margin_o), 32'({m[1:0], m[1:0]}));
			xfer(ctl(pmb_pkg::CMD_OPER, 1, 0, 1), 32'h0, r, s);
			chk(r, e);
		end
		// unlisted codes while on: both refused, margin high kept
		for (int i = 0; i < 2; i++) begin
			e = i ? 32'h0000_00b0 : 32'h0000_00c0;
			xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), e, r, s);
			chk(32'(cmd_err_o), 32'h1);
			xfer(ctl(pmb_pkg::CMD_CLEAR, 0, 0, 0), 32'h0, r, s);
			chk(32'(cmd_err_o), 32'h0);
		end
		xfer(ctl(pmb_pkg::CMD_OPER, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'h0000_00a0);
		$display("operation test done");
		v = rnd() & 32'h0000_ffff;
		t = rnd() & 32'h0000_ffff;
		xfer(ctl(pmb_pkg::CMD_VCMD, 0, 0, 2), v, r, s);
		chk(32'(vout_o), {v[15:0], v[15:0]});
		xfer(ctl(pmb_pkg::CMD_ONOFF, 0, 0, 1), 32'h0000_0016, r, s);
		xfer(ctl(pmb_pkg::CMD_ONOFF, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'h0000_0016);
		xfer(ctl(pmb_pkg::CMD_TRIM, 0, 0, 2), t, r, s);
		chk(32'(vout_o), {v[15:0], v[15:0]});
		xfer(ctl(pmb_pkg::CMD_TRIM, 1, 0, 2), 32'h0, r, s);
		chk(r, t);
		xfer(ctl(pmb_pkg::CMD_VCMD, 1, 0, 2), 32'h0, r, s);
		chk(r, v);
		wb(1'b0, pmb_pkg::REG_L11, 32'h0, w);
		chk(w & 32'hff00_ffff, l11(v[15:0]));
		// soft off: the ramp has ended before the next read arrives
		xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), 32'h0000_0040, r, s);
		xfer(ctl(pmb_pkg::CMD_OPER, 1, 0, 1), 32'h0, r, s);
		chk(r, 32'h0);
		xfer(ctl(pmb_pkg::CMD_OPER, 0, 0, 1), 32'h0000_0080, r, s);
		e = v + t;
		chk(32'(vout_o), {e[15:0], e[15:0]});
		$display("voltage test done");
		n = 1 + int'(rnd() % 4);
		w = 32'h0;
		for (int k = 0; k < n; k++) begin
			w[8*k +: 8] = 8'h20 + 8'(rnd() % 95);
		end
		xfer(ctl(pmb_pkg::CMD_TEXT, 0, 1, 3'(n)), w, r, s);
		xfer(ctl(pmb_pkg::CMD_TEXT, 1, 1, 3'h4), 32'h0, r, s);
		chk(32'(s[10:8]), 32'(n));
		chk(r & 32'((64'h1 << (8 * n)) - 64'h1), w);
		$display("text test done");
		xfer(ctl(pmb_pkg::CMD_STORE, 0, 0, 0), 32'h0, r, s);
		chk(32'(saw_nv), 32'h1);
		xfer(ctl(pmb_pkg::CMD_RESTORE, 0, 0, 0), 32'h0, r, s);
		xfer(ctl(pmb_pkg::CMD_OPER, 1, 0, 1), 32'h0, r, s);
		chk(32'(s[1]), 32'h0);
		chk(r, 32'h0);
		chk(32'(phase_on_o), 32'h0);
		$display("store test done");
		xfer(ctl(8'h99, 1, 0, 1), 32'h0, r, s);
		chk(32'(s[1]), 32'h1);
		wb(1'b1, 5'h14, 32'hffff_ffff, r);
		wb(1'b0, 5'h14, 32'h0, r);
		chk(r, 32'h0);
		// byte lanes: only selected data bytes land
		sel_i <= 4'h5;
		wb(1'b1, pmb_pkg::REG_WDATA, 32'h1234_5678, r);
		sel_i <= 4'hf;
		wb(1'b0, pmb_pkg::REG_WDATA, 32'h0, r);
		chk(r, 32'h0034_0078);
		$display("refusal test done");
		stop_test();
	end
endmodule
